// ==== shared/ssbr_params.svh ====
// Constants for the supply select, boot strap and reset block.
// Assumes a single 200 MHz clock and includes from shared/.
`ifndef SSBR_PARAMS_SVH
`define SSBR_PARAMS_SVH

// Clock rate
`define SSBR_CLK_MHZ        200
// Strap settling time before classification, ns (least time)
`define SSBR_STRAP_SETTLE_NS 500
`define SSBR_STRAP_CYC ((`SSBR_STRAP_SETTLE_NS*`SSBR_CLK_MHZ+999)/1000)
// Hard reset hold time after main supply loss, ns (least time)
`define SSBR_HARD_RST_NS    1000
`define SSBR_HARD_RST_CYC ((`SSBR_HARD_RST_NS*`SSBR_CLK_MHZ+999)/1000)
// Default system reset release delay, ns (least time)
`define SSBR_REL_NS         10000
`define SSBR_REL_CYC ((`SSBR_REL_NS*`SSBR_CLK_MHZ+999)/1000)
// Counter width for all timers
`define SSBR_CNT_W          12
// Reset value of the manual reset polarity: active high
`define SSBR_MR_ACT_LOW_RST 1'b0

`endif

// ==== shared/ssbr_pkg.sv ====
// Types for the supply select, boot strap and reset block.
// Assumes the constants header is compiled alongside.
`default_nettype none
package ssbr_pkg;

    // Boot and supply sequence, Gray coded along the usual path
    typedef enum logic [2:0] {
        SSBR_POR_WAIT  = 3'h0,
        SSBR_STRAP     = 3'h1,
        SSBR_RUN_FLASH = 3'h3,
        SSBR_RUN_ADP   = 3'h2,
        SSBR_HARD_RST  = 3'h6
    } ssbr_state_e;

    // Analog comparator levels from the pins
    typedef struct packed {
        logic main_good;      // main_3v3_supply_in above its good level
        logic adapter_good;   // adapter_input_rail above its good level
        logic main_below;     // main_3v3_supply_in below 2.85 V
        logic strap_adapter;  // power_path_strap in adapter-power range
        logic vout_uv;        // switched_3v3_output undervoltage
        logic manual_reset;   // manual_reset_in raw pin level
    } ssbr_sense_s;

    // Programmable enable conditions of the switched output
    typedef struct packed {
        logic enable;         // Software request to enable
        logic need_main;      // Only while main supply is good
        logic need_run;       // Only once application runs
    } ssbr_vout_cfg_s;

    // Boot outcome seen by the digital core
    typedef struct packed {
        logic core_run;       // Core released to execute boot code
        logic flash_load;     // Load application code from SPI flash
        logic adapter_sys;    // System powered via adapter switch
    } ssbr_boot_s;

endpackage
`default_nettype wire

// ==== hdl/ssbr_sync.sv ====
// Two flip-flop synchroniser, one stage pair per bit.
// Assumes inputs arrive asynchronous to sys_clk_in.
`timescale 1ns/1ps
`default_nettype none
module ssbr_sync #(
    parameter int WIDTH = 6
) (
    input  wire logic             sys_clk_in,  // System clock
    input  wire logic             arst_n_in,   // Async reset, low
    input  wire logic [WIDTH-1:0] async_in,    // Raw pin levels
    output logic      [WIDTH-1:0] sync_out     // Synchronised levels
);

    // One stage pair per bit; first stage feeds only the second
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        logic meta_q;
        logic sync_q;
        always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
            if (!arst_n_in) begin
                meta_q <= 1'b0;
                sync_q <= 1'b0;
            end else begin
                meta_q <= async_in[i];
                sync_q <= meta_q;
            end
        end
        assign sync_out[i] = sync_q;
    end

endmodule
`default_nettype wire

// ==== hdl/ssbr_top.sv ====
// Supply source choice, boot strap read and system reset control.
// Assumes comparator outputs arrive on pins asynchronously and the
// configuration inputs come from core logic on sys_clk_in.
`timescale 1ns/1ps
`default_nettype none
`include "ssbr_params.svh"
module ssbr_top #(
    parameter int REL_CYC = `SSBR_REL_CYC
) (
    input  wire logic           sys_clk_in,        // 200 MHz clock
    input  wire logic           arst_n_in,         // Async reset, low
    input  wire ssbr_pkg::ssbr_sense_s sense_in,   // Comparator pins
    input  wire ssbr_pkg::ssbr_vout_cfg_s vout_cfg_in, // Output config
    input  wire logic           mr_active_low_in,  // Manual reset pol.
    input  wire logic           mr_pol_load_in,    // Load polarity
    output logic                supply_sel_main_out, // 1 main, 0 adp
    output logic                adp_switch_close_out, // Adapter switch
    output ssbr_pkg::ssbr_boot_s boot_out,         // Boot outcome
    output logic                vout_switch_en_out, // Output switch
    output logic                vout_pulldown_en_out, // Output pull-down
    output logic                system_reset_out_n  // System reset, low
);

    localparam logic [`SSBR_CNT_W-1:0] STRAP_CYC =
        `SSBR_CNT_W'(`SSBR_STRAP_CYC);
    localparam logic [`SSBR_CNT_W-1:0] HARD_CYC =
        `SSBR_CNT_W'(`SSBR_HARD_RST_CYC);
    localparam logic [`SSBR_CNT_W-1:0] REL_CNT = `SSBR_CNT_W'(REL_CYC);

    ssbr_pkg::ssbr_sense_s  sense_s;
    ssbr_pkg::ssbr_state_e  state_q;
    ssbr_pkg::ssbr_state_e  state_d;
    logic [`SSBR_CNT_W-1:0] tmr_q;
    logic [`SSBR_CNT_W-1:0] tmr_d;
    logic                   main_seen_q;
    logic                   adp_mode_q;
    logic                   mr_act_low_q;
    logic                   mr_asserted;
    logic                   rst_cause;
    logic [`SSBR_CNT_W-1:0] rel_q;
    logic                   rst_n_q;
    logic                   vout_en_q;
    logic                   running;
    logic                   any_good;

    // Pin levels pass two flip-flops before use
    ssbr_sync #(
        .WIDTH ($bits(ssbr_pkg::ssbr_sense_s))
    ) u_sync (
        .sys_clk_in (sys_clk_in),
        .arst_n_in  (arst_n_in),
        .async_in   (sense_in),
        .sync_out   (sense_s)
    );

    assign running  = (state_q == ssbr_pkg::SSBR_RUN_FLASH) ||
                      (state_q == ssbr_pkg::SSBR_RUN_ADP);
    assign any_good = sense_s.main_good || sense_s.adapter_good;

    // Sequence: wait for a good supply, read strap, run, hard reset
    always_comb begin
        state_d = state_q;
        tmr_d   = tmr_q;
        unique case (state_q)
            ssbr_pkg::SSBR_POR_WAIT: begin
                tmr_d = '0;
                if (any_good) begin
                    state_d = ssbr_pkg::SSBR_STRAP;
                end
            end
            ssbr_pkg::SSBR_STRAP: begin
                if (!any_good) begin
                    state_d = ssbr_pkg::SSBR_POR_WAIT;
                end else if (tmr_q >= STRAP_CYC - 1'b1) begin
                    tmr_d = '0;
                    // Exactly one of two ranges is taken
                    if (sense_s.strap_adapter) begin
                        state_d = ssbr_pkg::SSBR_RUN_ADP;
                    end else begin
                        state_d = ssbr_pkg::SSBR_RUN_FLASH;
                    end
                end else begin
                    tmr_d = tmr_q + 1'b1;
                end
            end
            ssbr_pkg::SSBR_RUN_FLASH,
            ssbr_pkg::SSBR_RUN_ADP: begin
                tmr_d = '0;
                // Main lost below 2.85 V after both were present
                if (main_seen_q && sense_s.main_below) begin
                    state_d = ssbr_pkg::SSBR_HARD_RST;
                end else if (!any_good) begin
                    state_d = ssbr_pkg::SSBR_POR_WAIT;
                end
            end
            ssbr_pkg::SSBR_HARD_RST: begin
                if (tmr_q >= HARD_CYC - 1'b1) begin
                    tmr_d   = '0;
                    state_d = ssbr_pkg::SSBR_POR_WAIT;
                end else begin
                    tmr_d = tmr_q + 1'b1;
                end
            end
            default: begin
                tmr_d   = '0;
                state_d = ssbr_pkg::SSBR_POR_WAIT;
            end
        endcase
    end

    // Sequence state and timer
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_q <= ssbr_pkg::SSBR_POR_WAIT;
            tmr_q   <= '0;
        end else begin
            state_q <= state_d;
            tmr_q   <= tmr_d;
        end
    end

    // Remember main and adapter both present while running
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            main_seen_q <= 1'b0;
        end else if (!running) begin
            main_seen_q <= 1'b0;
        end else if (sense_s.main_good && sense_s.adapter_good) begin
            main_seen_q <= 1'b1;
        end
    end

    // Strap outcome latched at classification, held while running
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            adp_mode_q <= 1'b0;
        end else if (state_d == ssbr_pkg::SSBR_RUN_ADP) begin
            adp_mode_q <= 1'b1;
        end else begin
            adp_mode_q <= 1'b0;
        end
    end

    // Source select: main wins whenever good, no reset on switch-over to main
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            supply_sel_main_out <= 1'b1;
        end else if (sense_s.main_good) begin
            supply_sel_main_out <= 1'b1;
        end else if (sense_s.adapter_good) begin
            supply_sel_main_out <= 1'b0;
        end
    end

    // Manual reset polarity, active high after reset
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            mr_act_low_q <= `SSBR_MR_ACT_LOW_RST;
        end else if (mr_pol_load_in) begin
            mr_act_low_q <= mr_active_low_in;
        end
    end

    assign mr_asserted = sense_s.manual_reset ^ mr_act_low_q;

    // Causes that hold the system reset low
    assign rst_cause = sense_s.vout_uv
                    || mr_asserted;

    // Release only after both causes clear and delay expires
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rel_q   <= '0;
            rst_n_q <= 1'b0;
        end else if (rst_cause) begin
            rel_q   <= '0;
            rst_n_q <= 1'b0;
        end else if (rel_q >= REL_CNT) begin
            rst_n_q <= 1'b1;
        end else begin
            rel_q <= rel_q + 1'b1;
        end
    end

    // Switched output enable from programmable conditions and main_good
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            vout_en_q <= 1'b0;
        end else begin
            vout_en_q <= vout_cfg_in.enable
                && (!vout_cfg_in.need_main || sense_s.main_good)
                && (!vout_cfg_in.need_run || running)
                && sense_s.main_good;
        end
    end

    // Outputs
    assign vout_switch_en_out   = vout_en_q;
    assign vout_pulldown_en_out = !vout_en_q;
    assign system_reset_out_n   = rst_n_q;
    assign adp_switch_close_out = adp_mode_q;
    assign boot_out.core_run    = state_q != ssbr_pkg::SSBR_POR_WAIT &&
                                  state_q != ssbr_pkg::SSBR_HARD_RST;
    assign boot_out.flash_load  = state_q == ssbr_pkg::SSBR_RUN_FLASH;
    assign boot_out.adapter_sys = adp_mode_q;

endmodule
`default_nettype wire

// ==== bench/ssbr_checker_asserts.sv ====
// Checker for the supply select, boot strap and reset block.
// Assumes one clock domain and the port names of ssbr_top.
`timescale 1ns/1ps
`default_nettype none
module ssbr_checker #(
    parameter int REL_CYC = 4
) (
    input wire logic                     sys_clk_in,           // Clock
    input wire logic                     arst_n_in,            // Reset
    input wire ssbr_pkg::ssbr_sense_s    sense_in,             // Pins
    input wire ssbr_pkg::ssbr_vout_cfg_s vout_cfg_in,          // Config
    input wire logic                     mr_active_low_in,     // Polarity
    input wire logic                     mr_pol_load_in,       // Load
    input wire logic                     supply_sel_main_out,  // Source
    input wire logic                     adp_switch_close_out, // Switch
    input wire ssbr_pkg::ssbr_boot_s     boot_out,             // Boot
    input wire logic                     vout_switch_en_out,   // Output
    input wire logic                     vout_pulldown_en_out, // Pull-down
    input wire logic                     system_reset_out_n    // Reset out
);
    logic        pol_q;
    logic [15:0] quiet_q;
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!arst_n_in);
    // Polarity copy and cycles since the rail last sagged
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pol_q   <= 1'h0;
            quiet_q <= 16'h0;
        end else begin
            if (mr_pol_load_in) begin
                pol_q <= mr_active_low_in;
            end
            quiet_q <= sense_in.vout_uv ? 16'h0 : quiet_q + 16'h1;
        end
    end
    a_pull_down:
        assert property (vout_pulldown_en_out == !vout_switch_en_out)
        else $error("pull-down not inverse of switch");
    a_out_config:
        assert property (vout_switch_en_out |->
            $past(vout_cfg_in.enable) && $past(sense_in.main_good, 3))
        else $error("output on without request or main");
    a_uv_reset:
        assert property (sense_in.vout_uv |-> ##[2:3] !system_reset_out_n)
        else $error("undervoltage left reset high");
    a_button_reset:
        assert property ((sense_in.manual_reset ^ pol_q) |->
            ##[2:3] !system_reset_out_n)
        else $error("manual reset left reset high");
    a_release_wait:
        assert property ($rose(system_reset_out_n) |-> quiet_q > REL_CYC)
        else $error("reset released too early");
    a_main_select:
        assert property (sense_in.main_good [*3] |=> supply_sel_main_out)
        else $error("main present but not selected");
    a_strap_time:
        assert property ($rose(boot_out.core_run) |->
            ##[99:101] (boot_out.flash_load || adp_switch_close_out))
        else $error("strap not classified in time");
    a_flash_excl:
        assert property (boot_out.flash_load |->
            !adp_switch_close_out && !boot_out.adapter_sys)
        else $error("adapter switch closed in flash mode");
    a_adp_path:
        assert property (adp_switch_close_out |->
            boot_out.adapter_sys && boot_out.core_run)
        else $error("adapter switch without adapter mode");
    a_no_brownout:
        assert property ($rose(supply_sel_main_out) && boot_out.core_run
            |=> boot_out.core_run [*4])
        else $error("core stopped on switch-over");
endmodule
`default_nettype wire

// ==== bench/ssbr_board_model.sv ====
// Board model: supplies, strap wiring, output rail and reset button.
// Assumes the bench sets presence; outputs are comparator levels.
`timescale 1ns/1ps
`default_nettype none
module ssbr_board_model (
    input  wire logic             main_on_in,   // Main supply present
    input  wire logic             adp_on_in,    // Adapter present
    input  wire logic             strap_gnd_in, // Strap tied to ground
    input  wire logic             uv_fault_in,  // Load drags rail down
    input  wire logic             button_in,    // Reset button level
    input  wire logic             vout_en_in,   // Output switch on
    output ssbr_pkg::ssbr_sense_s sense_out     // Comparator levels
);
    // Output rail only stands while the switch feeds it from main
    assign sense_out = {main_on_in, adp_on_in, !main_on_in, strap_gnd_in,
        uv_fault_in | !(vout_en_in & main_on_in), button_in};
endmodule
`default_nettype wire

// ==== bench/tb_supply_select_boot_strap_reset.sv ====
// Bench for the supply select, boot strap and reset block.
// Assumes the board model on the pins; release count shortened to 4.
`timescale 1ns/1ps
`default_nettype none
module tb_supply_select_boot_strap_reset;
    localparam int REL = 4;
    logic                     sys_clk_in = 1'b0;
    logic                     arst_n_in = 1'b0;
    logic                     main_on = 1'b0, adp_on = 1'b0;
    logic                     strap_gnd = 1'b0, uv_fault = 1'b0;
    logic                     button = 1'b0, pol_low = 1'b0, pol_load = 1'b0;
    ssbr_pkg::ssbr_vout_cfg_s cfg = '0;
    ssbr_pkg::ssbr_sense_s    sense;
    ssbr_pkg::ssbr_boot_s     boot;
    logic                     sel, adp_sw, vout_en, pd, rst_n;
    int                       n_mismatch = 0;
    int                       checks = 0;
    // 200 MHz clock
    always #2.5 sys_clk_in = ~sys_clk_in;
    ssbr_board_model board_u (.main_on_in(main_on), .adp_on_in(adp_on),
        .strap_gnd_in(strap_gnd), .uv_fault_in(uv_fault),
        .button_in(button), .vout_en_in(vout_en), .sense_out(sense));
    ssbr_top #(.REL_CYC(REL)) dut_u (.sys_clk_in(sys_clk_in),
        .arst_n_in(arst_n_in), .sense_in(sense), .vout_cfg_in(cfg),
        .mr_active_low_in(pol_low), .mr_pol_load_in(pol_load),
        .supply_sel_main_out(sel), .adp_switch_close_out(adp_sw),
        .boot_out(boot), .vout_switch_en_out(vout_en),
        .vout_pulldown_en_out(pd), .system_reset_out_n(rst_n));
    task automatic look(input int n);
        repeat (n) @(posedge sys_clk_in);
        #1;
    endtask
    task automatic chk(input string what, input logic exp, input logic got);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic summarize;
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Adapter only, strap in no-adapter range: boot then flash load
    task automatic t_adapter_boot;
        look(10);
        chk("core_run", 1'b0, boot.core_run);
        @(posedge sys_clk_in);
        adp_on <= 1'b1;
        look(4);
        chk("core_run", 1'b1, boot.core_run);
        chk("source", 1'b0, sel);
        look(102);
        chk("flash_load", 1'b1, boot.flash_load);
        chk("adp_switch", 1'b0, adp_sw);
    endtask
    // Main joins later, strap moves: no reboot, strap stays frozen
    task automatic t_main_joins;
        @(posedge sys_clk_in);
        main_on <= 1'b1;
        strap_gnd <= 1'b1;
        look(5);
        chk("source", 1'b1, sel);
        chk("core_run", 1'b1, boot.core_run);
        chk("adp_switch", 1'b0, adp_sw);
        chk("vout_en idle", 1'b0, vout_en);
        @(posedge sys_clk_in);
        cfg <= 3'h7;
        look(3);
        chk("vout_en", 1'b1, vout_en);
        chk("pulldown", 1'b0, pd);
        look(REL + 6);
        chk("reset_n", 1'b1, rst_n);
    endtask
    // One reset cause on, then off: low, held, then released
    task automatic cause(input bit use_button, input logic on_lvl);
        @(posedge sys_clk_in);
        if (use_button)
            button <= on_lvl;
        else
            uv_fault <= 1'b1;
        look(4);
        chk("reset_n on", 1'b0, rst_n);
        @(posedge sys_clk_in);
        button <= use_button ? !on_lvl : button;
        uv_fault <= 1'b0;
        // Two sync cycles, then REL + 1 counted cycles before release
        look(REL + 2);
        chk("reset_n held", 1'b0, rst_n);
        look(1);
        chk("reset_n off", 1'b1, rst_n);
    endtask
    // Change button polarity with the pin at the new idle level
    task automatic set_pol(input logic low);
        @(posedge sys_clk_in);
        pol_low <= low;
        pol_load <= 1'b1;
        button <= low;
        @(posedge sys_clk_in);
        pol_load <= 1'b0;
        look(REL + 8);
        chk("reset_n idle", 1'b1, rst_n);
    endtask
    // Main lost with both present: hard reset, reboot on adapter path
    task automatic t_hard_reset;
        @(posedge sys_clk_in);
        main_on <= 1'b0;
        look(5);
        chk("core_run", 1'b0, boot.core_run);
        chk("vout_en", 1'b0, vout_en);
        chk("pulldown", 1'b1, pd);
        look(315);
        chk("core_run", 1'b1, boot.core_run);
        chk("adp_switch", 1'b1, adp_sw);
        chk("adapter_sys", 1'b1, boot.adapter_sys);
    endtask
    initial begin
        repeat (2) @(posedge sys_clk_in);
        arst_n_in <= 1'b1;
        t_adapter_boot();
        t_main_joins();
        cause(1'b0, 1'b1);
        cause(1'b1, 1'b1);
        set_pol(1'b1);
        cause(1'b1, 1'b0);
        set_pol(1'b0);
        t_hard_reset();
        summarize();
    end
    // Watchdog against a hang
    initial begin
        #8000;
        n_mismatch++;
        summarize();
    end
endmodule
bind ssbr_top ssbr_checker #(.REL_CYC(REL_CYC)) chk_u (
    .sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in), .sense_in(sense_in),
    .vout_cfg_in(vout_cfg_in), .mr_active_low_in(mr_active_low_in),
    .mr_pol_load_in(mr_pol_load_in),
    .supply_sel_main_out(supply_sel_main_out),
    .adp_switch_close_out(adp_switch_close_out), .boot_out(boot_out),
    .vout_switch_en_out(vout_switch_en_out),
    .vout_pulldown_en_out(vout_pulldown_en_out),
    .system_reset_out_n(system_reset_out_n));
`default_nettype wire
